/* File: sts_exec.sv */
// Purpose: execute stage for subtract, software trap, word/byte exchange and tests
// Assumes: memory answers on hclk; byte reads return the byte in rdata[7:0]
// Notes:   instructions are issued by writing the instruction register over AHB-Lite
`timescale 1ns/1ps
`include "sts_defs.svh"

module sts_exec (
   // clock and reset
   input  wire  logic                     hclk,
   input  wire  logic                     hresetn,
   // ahb-lite slave
   input  wire  logic                     hsel,
   input  wire  logic [31:0]              haddr,
   input  wire  logic [1:0]               htrans,
   input  wire  logic                     hwrite,
   input  wire  logic [2:0]               hsize,
   input  wire  logic [31:0]              hwdata,
   input  wire  logic                     hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [31:0]                    hrdata,
   // memory master
   output sts_pkg::sts_mem_req_type       mem_req,
   input  wire  sts_pkg::sts_mem_rsp_type mem_rsp,
   // interrupt
   output logic                           irq
);
   import sts_pkg::*;

   // architectural state
   logic [31:0]          gp_ff [0:14];
   logic [31:0]          pc_ff;
   logic [31:0]          status_ff;
   logic [31:0]          saved_ff [0:3];
   logic [31:0]          svc_link_ff;
   logic [1:0]           ctrl_ff;
   logic [3:0]           regsel_ff;
   logic [`STS_EV_W-1:0] ev_stat_ff;
   logic [`STS_EV_W-1:0] ev_mask_ff;
   // issue and exchange state
   logic [31:0]          instr_ff;
   logic                 issue_ff;
   sts_state_type        state_ff;
   logic [3:0]           sw_dst_ff;
   logic                 sw_byte_ff;
   sts_mem_req_type      mem_ff;
   logic [31:0]          rd_hold_ff;
   // bus data phase
   logic                 wr_pend_ff;
   logic [7:0]           wr_addr_ff;
   logic [31:0]          hrdata_ff;

   // decode and execute results
   logic                 cond_ok;
   logic                 is_swap;
   logic                 is_trap;
   logic                 is_dp;
   logic [3:0]           opc;
   logic                 s_bit;
   logic [3:0]           rd_idx;
   logic [31:0]          rn_val;
   logic [31:0]          rm_val;
   logic [31:0]          rs_val;
   logic [31:0]          op2;
   logic                 sh_carry;
   logic [32:0]          sh_tmp;
   logic [4:0]           sh_amt;
   logic [4:0]           rot;
   logic [32:0]          diff;
   logic [31:0]          alu;
   logic                 sub_v;
   logic                 exec;
   logic                 do_sub;
   logic                 do_test;
   logic                 do_trap;
   logic                 do_swap;
   logic                 align_fault;
   logic                 unknown;
   logic [31:0]          rd_word;
   logic [`STS_EV_W-1:0] ev_set;
   logic                 bus_wr;
   logic                 bus_rd;

   // saved-word slot for a mode; user/system share the last slot (their restore is undefined)
   function automatic logic [1:0] saved_slot(input logic [4:0] mode);
      logic [1:0] s;
      s = 2'h3;
      if (mode == `STS_MODE_FIQ) s = 2'h0;
      if (mode == `STS_MODE_IRQ) s = 2'h1;
      if (mode == `STS_MODE_SVC) s = 2'h2;
      return s;
   endfunction : saved_slot

   // register read, R15 reads as the instruction address plus eight
   function automatic logic [31:0] reg_rd(input logic [3:0] idx, input logic [31:0] pc,
                                          input logic [31:0] r [0:14]);
      return (idx == `STS_PC_REG) ? pc + `STS_PC_READ_AHEAD : r[idx];
   endfunction : reg_rd

   // condition field against current flags
   function automatic logic cond_pass(input logic [3:0] c, input logic [31:0] st);
      logic n, z, cf, v, r;
      n  = st[`STS_N_BIT];
      z  = st[`STS_Z_BIT];
      cf = st[`STS_C_BIT];
      v  = st[`STS_V_BIT];
      unique case (c[3:1])
         3'h0: r = z;
         3'h1: r = cf;
         3'h2: r = n;
         3'h3: r = v;
         3'h4: r = cf & ~z;
         3'h5: r = (n == v);
         3'h6: r = ~z & (n == v);
         3'h7: r = 1'b1;
      endcase
      // odd codes invert, except the always code
      return (c[0] && c[3:1] != 3'h7) ? ~r : r;
   endfunction : cond_pass

   // decode; the exchange pattern overlaps data processing so it is checked first
   always_comb begin
      is_swap = (instr_ff[27:23] == 5'h02) && (instr_ff[21:20] == 2'h0) && (instr_ff[11:4] == 8'h09);
      is_trap = (instr_ff[27:24] == 4'hf);
      is_dp   = (instr_ff[27:26] == 2'h0) && !is_swap;
      opc     = instr_ff[24:21];
      s_bit   = instr_ff[`STS_S_BIT];
      rd_idx  = instr_ff[15:12];
      rn_val  = reg_rd(instr_ff[19:16], pc_ff, gp_ff);
      rm_val  = reg_rd(instr_ff[3:0], pc_ff, gp_ff);
      rs_val  = reg_rd(instr_ff[11:8], pc_ff, gp_ff);
   end

   // shifter operand
   always_comb begin
      op2      = rm_val;
      sh_carry = status_ff[`STS_C_BIT];
      sh_tmp   = 33'h000000000;
      rot      = {instr_ff[11:8], 1'b0};
      sh_amt   = instr_ff[4] ? rs_val[4:0] : instr_ff[11:7];
      if (instr_ff[`STS_IMM_BIT]) begin
         op2 = ({24'h000000, instr_ff[7:0]} >> rot) | ({24'h000000, instr_ff[7:0]} << (6'h20 - {1'b0, rot}));
         if (rot != 5'h00) sh_carry = op2[31];
      end else if (sh_amt != 5'h00) begin
         unique case (instr_ff[6:5])
            2'h0: begin
               sh_tmp   = {1'b0, rm_val} << sh_amt;
               op2      = sh_tmp[31:0];
               sh_carry = sh_tmp[32];
            end
            2'h1: begin
               sh_tmp   = {rm_val, 1'b0} >> sh_amt;
               op2      = sh_tmp[32:1];
               sh_carry = sh_tmp[0];
            end
            2'h2: begin
               sh_tmp   = 33'($signed({rm_val, 1'b0}) >>> sh_amt);
               op2      = sh_tmp[32:1];
               sh_carry = sh_tmp[0];
            end
            2'h3: begin
               op2      = (rm_val >> sh_amt) | (rm_val << (6'h20 - {1'b0, sh_amt}));
               sh_carry = op2[31];
            end
         endcase
      end
   end

   // alu and dispatch
   always_comb begin
      diff  = {1'b0, rn_val} - {1'b0, op2};
      sub_v = (rn_val[31] ^ op2[31]) & (rn_val[31] ^ diff[31]);
      unique case (opc)
         `STS_OP_TST: alu = rn_val & op2;
         `STS_OP_TEQ: alu = rn_val ^ op2;
         default:     alu = diff[31:0];
      endcase
      cond_ok     = cond_pass(instr_ff[31:28], status_ff);
      exec        = issue_ff && cond_ok;
      do_sub      = exec && is_dp && (opc == `STS_OP_SUB);
      do_test     = exec && is_dp && (opc == `STS_OP_TST || opc == `STS_OP_TEQ) && s_bit;
      do_trap     = exec && is_trap;
      do_swap     = exec && is_swap;
      unknown     = exec && !do_sub && !do_test && !do_trap && !do_swap;
      align_fault = do_swap && !instr_ff[22] && ctrl_ff[`STS_CTRL_ALIGN] && ctrl_ff[`STS_CTRL_COPRO]
                    && (rn_val[1:0] != 2'h0);
   end

   // word returned by the exchange read
   always_comb begin
      rd_word = (mem_rsp.rdata >> {mem_ff.addr[1:0], 3'h0}) | (mem_rsp.rdata << (6'h20 - {1'b0, mem_ff.addr[1:0], 3'h0}));
      if (sw_byte_ff) rd_word = {24'h000000, mem_rsp.rdata[7:0]};
   end

   // bus phases
   assign bus_rd    = hsel && htrans[1] && hready && !hwrite;
   assign bus_wr    = wr_pend_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign mem_req   = mem_ff;
   assign irq       = |(ev_stat_ff & ev_mask_ff);

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= hsel && htrans[1] && hready && hwrite;
         wr_addr_ff <= haddr[7:0];
      end
   end

   // read data registered at the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (bus_rd) begin
         unique case (haddr[7:0])
            `STS_OFF_INSTR:   hrdata_ff <= instr_ff;
            `STS_OFF_PC:      hrdata_ff <= pc_ff;
            `STS_OFF_STATUS:  hrdata_ff <= status_ff;
            `STS_OFF_SAVED:   hrdata_ff <= saved_ff[saved_slot(status_ff[4:0])];
            `STS_OFF_REGSEL:  hrdata_ff <= {28'h0000000, regsel_ff};
            `STS_OFF_REGDATA: hrdata_ff <= reg_rd(regsel_ff, pc_ff, gp_ff);
            `STS_OFF_SVCLINK: hrdata_ff <= svc_link_ff;
            `STS_OFF_CTRL:    hrdata_ff <= {30'h00000000, ctrl_ff};
            `STS_OFF_STATE:   hrdata_ff <= {29'h00000000, issue_ff, state_ff};
            `STS_OFF_EVSTAT:  hrdata_ff <= {27'h0000000, ev_stat_ff};
            `STS_OFF_EVMASK:  hrdata_ff <= {27'h0000000, ev_mask_ff};
            default:          hrdata_ff <= 32'h00000000;
         endcase
      end
   end

   // instruction issue; writes while busy are dropped so an exchange is never torn
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_ff <= 32'h00000000;
         issue_ff <= 1'b0;
      end else begin
         issue_ff <= 1'b0;
         if (bus_wr && wr_addr_ff == `STS_OFF_INSTR && !issue_ff && state_ff == ST_IDLE) begin
            instr_ff <= hwdata;
            issue_ff <= 1'b1;
         end
      end
   end

   // small software-owned settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff    <= 2'h0;
         regsel_ff  <= 4'h0;
         ev_mask_ff <= '0;
      end else if (bus_wr) begin
         if (wr_addr_ff == `STS_OFF_CTRL)   ctrl_ff    <= hwdata[1:0];
         if (wr_addr_ff == `STS_OFF_REGSEL) regsel_ff  <= hwdata[3:0];
         if (wr_addr_ff == `STS_OFF_EVMASK) ev_mask_ff <= hwdata[`STS_EV_W-1:0];
      end
   end

   // program counter; execution outranks a software write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_ff <= 32'h00000000;
      end else if (do_trap) begin
         pc_ff <= `STS_TRAP_VECTOR;
      end else if (do_sub && rd_idx == `STS_PC_REG) begin
         pc_ff <= alu;
      end else if (issue_ff) begin
         pc_ff <= pc_ff + `STS_PC_STEP;
      end else if (bus_wr && wr_addr_ff == `STS_OFF_PC) begin
         pc_ff <= hwdata;
      end
   end

   // current status word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_ff <= `STS_STATUS_RST;
      end else if (do_trap) begin
         status_ff[5:0] <= `STS_SVC_MODE6;
         status_ff[`STS_IRQ_OFF_BIT] <= 1'b1;
      end else if (do_sub && s_bit && rd_idx == `STS_PC_REG) begin
         status_ff <= saved_ff[saved_slot(status_ff[4:0])];
      end else if (do_sub && s_bit) begin
         status_ff[`STS_N_BIT] <= alu[31];
         status_ff[`STS_Z_BIT] <= (alu == 32'h00000000);
         status_ff[`STS_C_BIT] <= ~diff[32];
         status_ff[`STS_V_BIT] <= sub_v;
      end else if (do_test) begin
         status_ff[`STS_N_BIT] <= alu[31];
         status_ff[`STS_Z_BIT] <= (alu == 32'h00000000);
         status_ff[`STS_C_BIT] <= sh_carry;
      end else if (bus_wr && wr_addr_ff == `STS_OFF_STATUS) begin
         status_ff <= hwdata;
      end
   end

   // saved status words and supervisor link
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         svc_link_ff <= 32'h00000000;
         for (int i = 0; i < 4; i++) saved_ff[i] <= 32'h00000000;
      end else if (do_trap) begin
         svc_link_ff <= pc_ff + `STS_PC_STEP;
         saved_ff[saved_slot(`STS_MODE_SVC)] <= status_ff;
      end else if (bus_wr) begin
         if (wr_addr_ff == `STS_OFF_SVCLINK) svc_link_ff <= hwdata;
         if (wr_addr_ff == `STS_OFF_SAVED) saved_ff[saved_slot(status_ff[4:0])] <= hwdata;
      end
   end

   // general registers; test forms write none
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 15; i++) gp_ff[i] <= 32'h00000000;
      end else if (state_ff == ST_WRITE && mem_rsp.ack && !mem_rsp.abort && sw_dst_ff != `STS_PC_REG) begin
         gp_ff[sw_dst_ff] <= rd_hold_ff;
      end else if (do_sub && rd_idx != `STS_PC_REG) begin
         gp_ff[rd_idx] <= alu;
      end else if (bus_wr && wr_addr_ff == `STS_OFF_REGDATA && regsel_ff != `STS_PC_REG) begin
         gp_ff[regsel_ff] <= hwdata;
      end
   end

   // exchange sequencer: locked read then write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff   <= ST_IDLE;
         mem_ff     <= '0;
         sw_dst_ff  <= 4'h0;
         sw_byte_ff <= 1'b0;
         rd_hold_ff <= 32'h00000000;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (do_swap && !align_fault) begin
                  mem_ff.req     <= 1'b1;
                  mem_ff.write   <= 1'b0;
                  mem_ff.lock    <= 1'b1;
                  mem_ff.byte_sz <= instr_ff[22];
                  mem_ff.addr    <= rn_val;
                  // low source byte for byte form
                  mem_ff.wdata   <= instr_ff[22] ? {24'h000000, rm_val[7:0]} : rm_val;
                  sw_dst_ff      <= rd_idx;
                  sw_byte_ff     <= instr_ff[22];
                  state_ff       <= ST_READ;
               end
            end
            ST_READ: begin
               if (mem_rsp.ack && mem_rsp.abort) begin
                  mem_ff   <= '0;
                  state_ff <= ST_IDLE;
               end else if (mem_rsp.ack) begin
                  // keep read word until the store is clean
                  mem_ff.write <= 1'b1;
                  // rdata is only valid with the load's ack, so hold it for the store phase
                  rd_hold_ff   <= rd_word;
                  state_ff     <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (mem_rsp.ack) begin
                  mem_ff   <= '0;
                  state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // event sources
   always_comb begin
      ev_set                 = '0;
      ev_set[`STS_EV_DONE]   = (issue_ff && !do_swap) || align_fault
                               || (state_ff != ST_IDLE && mem_rsp.ack && (mem_rsp.abort || state_ff == ST_WRITE));
      ev_set[`STS_EV_ABORT]  = (state_ff != ST_IDLE) && mem_rsp.ack && mem_rsp.abort;
      ev_set[`STS_EV_ALIGN]  = align_fault;
      ev_set[`STS_EV_TRAP]   = do_trap;
      ev_set[`STS_EV_UNKNOWN] = unknown;
   end

   // sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_stat_ff <= '0;
      end else if (bus_wr && wr_addr_ff == `STS_OFF_EVSTAT) begin
         ev_stat_ff <= (ev_stat_ff & ~hwdata[`STS_EV_W-1:0]) | ev_set;
      end else begin
         ev_stat_ff <= ev_stat_ff | ev_set;
      end
   end

endmodule : sts_exec

/* File: sts_defs.svh */
// Purpose: named constants for the subtract/trap/swap/test execute block
// Assumes: included by bare name, no processes here
// Notes:   byte offsets are decoded from haddr[7:0]
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

// register byte offsets
`define STS_OFF_INSTR    8'h00
`define STS_OFF_PC       8'h04
`define STS_OFF_STATUS   8'h08
`define STS_OFF_SAVED    8'h0c
`define STS_OFF_REGSEL   8'h10
`define STS_OFF_REGDATA  8'h14
`define STS_OFF_SVCLINK  8'h18
`define STS_OFF_CTRL     8'h1c
`define STS_OFF_STATE    8'h20
`define STS_OFF_EVSTAT   8'h24
`define STS_OFF_EVMASK   8'h28

// status word fields
`define STS_N_BIT        31
`define STS_Z_BIT        30
`define STS_C_BIT        29
`define STS_V_BIT        28
`define STS_IRQ_OFF_BIT  7
`define STS_SVC_MODE6    6'h13
`define STS_MODE_FIQ     5'h11
`define STS_MODE_IRQ     5'h12
`define STS_MODE_SVC     5'h13
`define STS_STATUS_RST   32'h000000d3

// instruction fields
`define STS_IMM_BIT      25
`define STS_S_BIT        20
`define STS_OP_SUB       4'h2
`define STS_OP_TST       4'h8
`define STS_OP_TEQ       4'h9
`define STS_TRAP_VECTOR  32'h00000008
`define STS_PC_STEP      32'h00000004
`define STS_PC_READ_AHEAD 32'h00000008
`define STS_PC_REG       4'hf

// control bits
`define STS_CTRL_ALIGN   0
`define STS_CTRL_COPRO   1

// event bits
`define STS_EV_W         5
`define STS_EV_DONE      0
`define STS_EV_ABORT     1
`define STS_EV_ALIGN     2
`define STS_EV_TRAP      3
`define STS_EV_UNKNOWN   4

`endif

/* File: sts_pkg.sv */
// Purpose: types shared by the execute block and its bench
// Assumes: constants live in sts_defs.svh
// Notes:   memory request is level, held until ack
package sts_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } sts_state_type;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        byte_sz;
      logic        lock;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sts_mem_req_type;

   typedef struct packed {
      logic        ack;
      logic        abort;
      logic [31:0] rdata;
   } sts_mem_rsp_type;

endpackage : sts_pkg

/* File: sts_exec_checker.sv */
// Purpose: protocol checks on the exchange memory port
// Assumes: one clock, async active-low reset
// Notes:   sees top ports only, attached by bind
`timescale 1ns/1ps
module sts_exec_checker (
   // clock and reset
   input wire logic                     hclk,
   input wire logic                     hresetn,
   // memory port
   input wire sts_pkg::sts_mem_req_type mem_req,
   input wire sts_pkg::sts_mem_rsp_type mem_rsp
);
   import sts_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // completed read and completed write steps of one exchange
   sequence s_rd_done;
      mem_req.req && !mem_req.write && mem_rsp.ack;
   endsequence
   sequence s_wr_done;
      mem_req.req && mem_req.write && mem_rsp.ack;
   endsequence
   property p_lock;
      mem_req.req |-> mem_req.lock;
   endproperty
   a_lock: assert property (p_lock) else $error("access without lock");
   property p_hold;
      mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable({mem_req.write, mem_req.addr});
   endproperty
   a_hold: assert property (p_hold) else $error("request changed before ack");
   property p_rd_wr;
      s_rd_done ##0 !mem_rsp.abort |=> mem_req.write && mem_req.addr == $past(mem_req.addr);
   endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("store does not follow load");
   property p_rd_abort;
      s_rd_done ##0 mem_rsp.abort |=> !mem_req.req && !mem_req.lock;
   endproperty
   a_rd_abort: assert property (p_rd_abort) else $error("store after aborted load");
   property p_wr_end;
      s_wr_done |=> !mem_req.req && !mem_req.lock;
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("request kept after store");
   property p_byte;
      mem_req.req && mem_req.write && mem_req.byte_sz |-> mem_req.wdata[31:8] == 24'h0;
   endproperty
   a_byte: assert property (p_byte) else $error("byte store upper bits set");
   property p_first;
      $rose(mem_req.req) |-> !mem_req.write;
   endproperty
   a_first: assert property (p_first) else $error("exchange opened by store");
   property p_unlock;
      $fell(mem_req.lock) |-> $past(mem_rsp.ack);
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock dropped mid exchange");
endmodule : sts_exec_checker

bind sts_exec sts_exec_checker sts_exec_checker_i (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_rsp(mem_rsp));

/* File: sts_mem_model.sv */
// Purpose: memory answering the exchange port
// Assumes: word k resets to 44332211 plus k in the top byte
// Notes:   delay and aborts are set by the bench
`timescale 1ns/1ps
module sts_mem_model (
   // clock and reset
   input wire logic                     hclk,
   input wire logic                     hresetn,
   // memory port
   input wire sts_pkg::sts_mem_req_type mem_req,
   output sts_pkg::sts_mem_rsp_type     mem_rsp,
   // behaviour control
   input wire logic [3:0]               dly,
   input wire logic                     abort_rd,
   input wire logic                     abort_wr
);
   import sts_pkg::*;
   logic [31:0] mem [0:15];
   logic [3:0]  wait_ff;
   logic [31:0] word;
   assign word = mem[mem_req.addr[5:2]];
   // ack after dly cycles; rdata toggles outside the ack so stale data never matches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_ff <= 4'h0;
         mem_rsp <= '0;
         for (int k = 0; k < 16; k++) mem[k] <= 32'h44332211 + {k[7:0], 24'h0};
      end else begin
         mem_rsp.ack <= 1'b0;
         mem_rsp.abort <= 1'b0;
         mem_rsp.rdata <= ~mem_rsp.rdata;
         if (mem_req.req && !mem_rsp.ack) begin
            wait_ff <= (wait_ff == dly) ? 4'h0 : wait_ff + 4'h1;
            if (wait_ff == dly) begin
               mem_rsp.ack <= 1'b1;
               mem_rsp.abort <= mem_req.write ? abort_wr : abort_rd;
               // a store's ack carries no data, so rdata keeps toggling there
               if (!mem_req.write)
                  mem_rsp.rdata <= mem_req.byte_sz ? {24'h0, word[{mem_req.addr[1:0], 3'h0} +: 8]} : word;
               if (mem_req.write && !abort_wr && mem_req.byte_sz)
                  mem[mem_req.addr[5:2]][{mem_req.addr[1:0], 3'h0} +: 8] <= mem_req.wdata[7:0];
               else if (mem_req.write && !abort_wr)
                  mem[mem_req.addr[5:2]] <= mem_req.wdata;
            end
         end
      end
   end
endmodule : sts_mem_model

/* File: test_sts_exec.sv */
// Purpose: self-checking bench of the execute block
// Assumes: zero-wait slave, memory model on the exchange port
// Notes:   reset checks first, then table rows, then hand-written cases
`timescale 1ns/1ps
module test_sts_exec;
   import sts_pkg::*;
   typedef struct packed {
      logic [31:0] ins;
      logic [31:0] a;
      logic [31:0] b;
      logic [3:0]  f;
      logic [31:0] r3;
   } sts_row_type;
   logic            hclk = 1'b0;
   logic            hresetn = 1'b0;
   logic            hsel = 1'b0;
   logic [31:0]     haddr = 32'h0;
   logic [1:0]      htrans = 2'h0;
   logic            hwrite = 1'b0;
   logic [31:0]     hwdata = 32'h0;
   logic            hreadyout;
   logic            hresp;
   logic            irq;
   logic [31:0]     hrdata;
   logic [31:0]     v;
   sts_mem_req_type mem_req;
   sts_mem_rsp_type mem_rsp;
   logic [3:0]      dly = 4'h0;
   logic            abort_rd = 1'b0;
   logic            abort_wr = 1'b0;
   int              error_cnt = 0;
   int              comparisons = 0;
   sts_row_type     rows [0:7];
   sts_exec sts_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .irq(irq));
   sts_mem_model sts_mem_model_i (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .dly(dly), .abort_rd(abort_rd), .abort_wr(abort_wr));
   // 50 MHz clock
   always #10 hclk = ~hclk;
   // one word transfer; answers are awaited, never assumed
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic setr(input logic [3:0] r, input logic [31:0] d);
      xfer(8'h10, 1'b1, {28'h0, r}, v);
      xfer(8'h14, 1'b1, d, v);
   endtask : setr
   task automatic getr(input logic [3:0] r);
      xfer(8'h10, 1'b1, {28'h0, r}, v);
      xfer(8'h14, 1'b0, 32'h0, v);
   endtask : getr
   // issue, then poll the state word until idle
   task automatic run(input logic [31:0] ins);
      xfer(8'h00, 1'b1, ins, v);
      do xfer(8'h20, 1'b0, 32'h0, v); while (v[2:0] !== 3'h0);
   endtask : run
   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   // watchdog well beyond the expected run
   initial begin
      #400000;
      error_cnt++;
      finish_test;
   end
   initial begin
      rows[0] = '{32'he0513002, 32'h5, 32'h5, 4'h6, 32'h0};
      rows[1] = '{32'he0513002, 32'h0, 32'h1, 4'h8, 32'hffffffff};
      rows[2] = '{32'he0513002, 32'h80000000, 32'h1, 4'h3, 32'h7fffffff};
      rows[3] = '{32'he2513010, 32'h10, 32'h0, 4'h6, 32'h0};
      rows[4] = '{32'he0413002, 32'h3, 32'h1, 4'h1, 32'h2};
      rows[5] = '{32'h00513002, 32'h5, 32'h5, 4'h1, 32'habcd};
      rows[6] = '{32'he33104ff, 32'hff000000, 32'h0, 4'h7, 32'habcd};
      rows[7] = '{32'he1110002, 32'h80000001, 32'h80000000, 4'h9, 32'habcd};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(8'h08, 1'b0, 32'h0, v);
      chk("status reset", v, 32'h000000d3);
      xfer(8'h3c, 1'b0, 32'h0, v);
      chk("unmapped", v, 32'h0);
      chk("hresp", {31'h0, hresp}, 32'h0);
      // flags, operand form, condition and tests per row
      for (int i = 0; i < 8; i++) begin
         xfer(8'h08, 1'b1, 32'h100000d3, v);
         setr(4'h1, rows[i].a);
         setr(4'h2, rows[i].b);
         setr(4'h3, 32'habcd);
         run(rows[i].ins);
         xfer(8'h08, 1'b0, 32'h0, v);
         chk("flags", {28'h0, v[31:28]}, {28'h0, rows[i].f});
         getr(4'h3);
         chk("dest", v, rows[i].r3);
      end
      // program counter targets from privileged mode, then a trap taken from user mode
      xfer(8'h04, 1'b1, 32'h100, v);
      setr(4'h1, 32'h200);
      setr(4'h2, 32'h10);
      run(32'he041f002);
      xfer(8'h04, 1'b0, 32'h0, v);
      chk("pc", v, 32'h1f0);
      xfer(8'h0c, 1'b1, 32'ha0000010, v);
      run(32'he051f002);
      xfer(8'h08, 1'b0, 32'h0, v);
      chk("status", v, 32'ha0000010);
      xfer(8'h04, 1'b1, 32'h300, v);
      xfer(8'h08, 1'b1, 32'h60000010, v);
      xfer(8'h24, 1'b1, 32'h1f, v);
      xfer(8'h28, 1'b1, 32'h08, v);
      run(32'hef000123);
      xfer(8'h18, 1'b0, 32'h0, v);
      chk("link", v, 32'h304);
      xfer(8'h04, 1'b0, 32'h0, v);
      chk("pc", v, 32'h8);
      xfer(8'h0c, 1'b0, 32'h0, v);
      chk("saved", v, 32'h60000010);
      xfer(8'h08, 1'b0, 32'h0, v);
      chk("status", v, 32'h60000093);
      chk("irq", {31'h0, irq}, 32'h1);
      xfer(8'h28, 1'b1, 32'h0, v);
      @(negedge hclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      xfer(8'h24, 1'b1, 32'h1f, v);
      xfer(8'h24, 1'b0, 32'h0, v);
      chk("events", v, 32'h0);
      dly <= 4'h2;
      setr(4'h1, 32'h5);
      setr(4'h2, 32'hcafef00d);
      run(32'he1013092);
      getr(4'h3);
      chk("rotated", v, 32'h11453322);
      chk("stored", sts_mem_model_i.mem[1], 32'hcafef00d);
      setr(4'h1, 32'ha);
      setr(4'h2, 32'h123456ee);
      run(32'he1413092);
      getr(4'h3);
      chk("byte", v, 32'h33);
      chk("byte mem", sts_mem_model_i.mem[2], 32'h46ee2211);
      // abort on load, then on store
      dly <= 4'h0;
      for (int j = 0; j < 2; j++) begin
         abort_rd <= (j == 0);
         abort_wr <= (j == 1);
         xfer(8'h24, 1'b1, 32'h1f, v);
         setr(4'h1, 32'h10);
         setr(4'h3, 32'h5a);
         run(32'he1013092);
         getr(4'h3);
         chk("abort dest", v, 32'h5a);
         xfer(8'h24, 1'b0, 32'h0, v);
         chk("abort ev", {31'h0, v[1]}, 32'h1);
      end
      abort_rd <= 1'b0;
      abort_wr <= 1'b0;
      xfer(8'h1c, 1'b1, 32'h3, v);
      setr(4'h1, 32'h5);
      run(32'he1013092);
      getr(4'h3);
      chk("align dest", v, 32'h5a);
      xfer(8'h24, 1'b0, 32'h0, v);
      chk("align ev", {31'h0, v[2]}, 32'h1);
      finish_test;
   end
endmodule : test_sts_exec
